//--- epi_defines.svh
`ifndef EPI_DEFINES_SVH
`define EPI_DEFINES_SVH
// ------------------------------
// register offsets
// ------------------------------
`define EPI_ADDR_MASK_LOW 8'h12
`define EPI_ADDR_MASK_HIGH 8'h13
`define EPI_ADDR_CONTROL 8'h35
`define EPI_ADDR_ENABLE 8'h3B
`define EPI_ADDR_FLAGS 8'h3A
// ------------------------------
// field positions and reset values
// ------------------------------
`define EPI_BIT_EXT 6
`define EPI_BIT_GRP1 5
`define EPI_BIT_GRP0 4
`define EPI_RST_BYTE 8'h00
`define EPI_RST_SENSE 2'h0
`define EPI_MASK_ENABLE 8'h70
`define EPI_MASK_HIGH 8'h0F
`endif

//--- epi_pkg.sv
`default_nettype none
package epi_pkg;
   typedef enum logic [1:0] {
      EPI_SENSE_LOW,
      EPI_SENSE_CHANGE,
      EPI_SENSE_FALL,
      EPI_SENSE_RISE
   } epi_sense_type;
   typedef struct packed {
      logic ext;
      logic grp1;
      logic grp0;
   } epi_irq_type;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } epi_bus_type;
endpackage
`default_nettype wire

//--- epi_src.sv
`default_nettype none
// ----------
// pin sources
// ----------
module epi_src (
   input wire logic clk,
   input wire logic pin_lvl,
   input wire logic [11:0] chg_lvl,
   output logic ext_irq_pin,
   output logic [11:0] chg_inputs
);
   timeunit 1ns;
   timeprecision 1ps;
   // whole-cycle levels only, so no pulse is shorter than a clock
   always_ff @(posedge clk) begin
      ext_irq_pin <= pin_lvl;
      chg_inputs <= chg_lvl;
   end
endmodule // epi_src
`default_nettype wire

//--- epi_unit.sv
// Overview of operation
// - external request needs global and pin enable
// - two-bit sense selects level, change, fall, rise
// - pin sampled first; one-clock pulses caught
// - unused enable, flag, high-mask bits read zero
// - enable bit 6 gates external pin vector
// - pin activity counts even when driven out
// - enable bit 5 gates inputs 11..8 group
// - enable bit 4 gates inputs 7..0 group
// - flag bit 6 sets on external edge
// - flags clear on vector taken or write-one
// - external flag stays clear in level mode
// - flag bit 5 sets on high-group change
// - flag bit 4 sets on low-group change
// - set, enabled flag vectors to its address
// - high mask bits 3..0 gate inputs 11..8
// - low mask at 0x12, eight bits, reset zero
// - pin-change wake raised without clock
// - low level wakes without clock; edges need it
// - level mode requests while pin held low
`include "epi_defines.svh"
`default_nettype none
module epi_unit #(
   parameter int CHG_WIDTH = 12
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [7:0] bus_rdata,
   input wire logic ext_irq_pin,
   input wire logic [CHG_WIDTH-1:0] chg_inputs,
   input wire logic cpu_status_i,
   input wire logic ack_ext,
   input wire logic ack_grp1,
   input wire logic ack_grp0,
   output epi_pkg::epi_irq_type irq_req,
   output logic wake_req
);
   initial begin
      if (CHG_WIDTH != 12) $error("epi_unit supports exactly twelve change inputs");
   end

   // ------------------------------
   // registers
   // ------------------------------
   epi_pkg::epi_bus_type bus;
   assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

   logic [7:0] mask_low_r;
   logic [3:0] mask_high_r;
   epi_pkg::epi_sense_type sense_r;
   epi_pkg::epi_irq_type enable_r;
   epi_pkg::epi_irq_type flag_r;

   // one process per register, unmapped writes simply fall through
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mask_low_r <= `EPI_RST_BYTE;
      end else if (bus.wr && bus.addr == `EPI_ADDR_MASK_LOW) begin
         mask_low_r <= bus.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mask_high_r <= 4'h0;
      end else if (bus.wr && bus.addr == `EPI_ADDR_MASK_HIGH) begin
         mask_high_r <= bus.wdata[3:0];
      end
   end

   // reset to level sense: no edge can be flagged before software chooses
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sense_r <= epi_pkg::epi_sense_type'(`EPI_RST_SENSE);
      end else if (bus.wr && bus.addr == `EPI_ADDR_CONTROL) begin
         sense_r <= epi_pkg::epi_sense_type'(bus.wdata[1:0]);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         enable_r <= '0;
      end else if (bus.wr && bus.addr == `EPI_ADDR_ENABLE) begin
         enable_r <= '{ext: bus.wdata[`EPI_BIT_EXT], grp1: bus.wdata[`EPI_BIT_GRP1],
                       grp0: bus.wdata[`EPI_BIT_GRP0]};
      end
   end

   // ------------------------------
   // input synchronisers
   // ------------------------------
   // pin is read regardless of its direction, so software can drive it
   logic ext_meta_r, ext_sync_r, ext_prev_r;
   logic [CHG_WIDTH-1:0] chg_meta_r, chg_sync_r, chg_prev_r;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ext_meta_r <= 1'b1;
         ext_sync_r <= 1'b1;
         ext_prev_r <= 1'b1;
      end else begin
         ext_meta_r <= ext_irq_pin;
         ext_sync_r <= ext_meta_r;
         ext_prev_r <= ext_sync_r;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < CHG_WIDTH; gi++) begin : g_sync
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               chg_meta_r[gi] <= 1'b0;
               chg_sync_r[gi] <= 1'b0;
               chg_prev_r[gi] <= 1'b0;
            end else begin
               chg_meta_r[gi] <= chg_inputs[gi];
               chg_sync_r[gi] <= chg_meta_r[gi];
               chg_prev_r[gi] <= chg_sync_r[gi];
            end
         end
      end
   endgenerate

   // ------------------------------
   // event detection
   // ------------------------------
   logic ext_event;
   logic grp1_event;
   logic grp0_event;
   logic [CHG_WIDTH-1:0] chg_toggle;

   assign chg_toggle = chg_sync_r ^ chg_prev_r;

   always_comb begin
      unique case (sense_r)
         epi_pkg::EPI_SENSE_LOW: ext_event = 1'b0;
         epi_pkg::EPI_SENSE_CHANGE: ext_event = ext_sync_r ^ ext_prev_r;
         epi_pkg::EPI_SENSE_FALL: ext_event = ext_prev_r & ~ext_sync_r;
         epi_pkg::EPI_SENSE_RISE: ext_event = ~ext_prev_r & ext_sync_r;
      endcase
   end

   // masked pins only; group enable also gates the flag
   assign grp1_event = enable_r.grp1 & |(chg_toggle[11:8] & mask_high_r);
   assign grp0_event = enable_r.grp0 & |(chg_toggle[7:0] & mask_low_r);

   // ------------------------------
   // flags
   // ------------------------------
   logic flag_wr;
   assign flag_wr = bus.wr && bus.addr == `EPI_ADDR_FLAGS;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flag_r <= '0;
      end else begin
         // set wins over a same-cycle clear
         if (sense_r == epi_pkg::EPI_SENSE_LOW) begin
            flag_r.ext <= 1'b0;
         end else if (ext_event) begin
            flag_r.ext <= 1'b1;
         end else if (ack_ext || (flag_wr && bus.wdata[`EPI_BIT_EXT])) begin
            flag_r.ext <= 1'b0;
         end
         if (grp1_event) begin
            flag_r.grp1 <= 1'b1;
         end else if (ack_grp1 || (flag_wr && bus.wdata[`EPI_BIT_GRP1])) begin
            flag_r.grp1 <= 1'b0;
         end
         if (grp0_event) begin
            flag_r.grp0 <= 1'b1;
         end else if (ack_grp0 || (flag_wr && bus.wdata[`EPI_BIT_GRP0])) begin
            flag_r.grp0 <= 1'b0;
         end
      end
   end

   // ------------------------------
   // requests
   // ------------------------------
   logic ext_level_low;
   logic global_en;
   // same clock domain as the core, so no synchroniser here
   assign global_en = cpu_status_i;
   assign ext_level_low = (sense_r == epi_pkg::EPI_SENSE_LOW) & ~ext_sync_r;

   // level source must outlast the current instruction, flag not kept
   always_comb begin
      irq_req.ext = global_en & enable_r.ext & (flag_r.ext | ext_level_low);
      irq_req.grp1 = global_en & enable_r.grp1 & flag_r.grp1;
      irq_req.grp0 = global_en & enable_r.grp0 & flag_r.grp0;
   end

   // raw pins, no clock needed: wakes a stopped clock domain
   logic [CHG_WIDTH-1:0] chg_armed;
   assign chg_armed = {mask_high_r & {4{enable_r.grp1}}, mask_low_r & {8{enable_r.grp0}}};
   assign wake_req = (|(chg_armed & (chg_inputs ^ chg_prev_r)))
                   | (enable_r.ext & (sense_r == epi_pkg::EPI_SENSE_LOW) & ~ext_irq_pin);

   // ------------------------------
   // read port
   // ------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bus_rdata <= 8'h00;
      end else if (bus.rd) begin
         unique case (bus.addr)
            `EPI_ADDR_MASK_LOW: bus_rdata <= mask_low_r;
            `EPI_ADDR_MASK_HIGH: bus_rdata <= {4'h0, mask_high_r};
            `EPI_ADDR_CONTROL: bus_rdata <= {6'h00, sense_r};
            `EPI_ADDR_ENABLE: bus_rdata <= {1'b0, enable_r, 4'h0};
            `EPI_ADDR_FLAGS: bus_rdata <= {1'b0, flag_r, 4'h0};
            default: bus_rdata <= 8'h00;
         endcase
      end else begin
         bus_rdata <= 8'h00;
      end
   end

   // ------------------------------
   // assertions
   // ------------------------------
   a_ext_gate: assert property (@(posedge clk) disable iff (sys_rst)
      irq_req.ext |-> cpu_status_i && enable_r.ext)
      else $error("external request without enables");
   a_level_flag_clear: assert property (@(posedge clk) disable iff (sys_rst)
      sense_r == epi_pkg::EPI_SENSE_LOW |=> flag_r.ext == 1'b0 || $past(sense_r) != epi_pkg::EPI_SENSE_LOW)
      else $error("external flag set in level mode");
   a_rise_sets_flag: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(ext_sync_r) && sense_r == epi_pkg::EPI_SENSE_RISE && !bus.wr |=> flag_r.ext)
      else $error("rising edge missed");
   a_fall_no_flag: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(ext_sync_r) && sense_r == epi_pkg::EPI_SENSE_FALL && !flag_r.ext |=> !flag_r.ext)
      else $error("rising edge flagged in fall mode");
   a_grp0_sets: assert property (@(posedge clk) disable iff (sys_rst)
      grp0_event |=> flag_r.grp0)
      else $error("low group change lost");
   a_grp1_masked: assert property (@(posedge clk) disable iff (sys_rst)
      !flag_r.grp1 && mask_high_r == 4'h0 && !bus.wr |=> !flag_r.grp1)
      else $error("masked high group flagged");
   a_write_one_clears: assert property (@(posedge clk) disable iff (sys_rst)
      flag_wr && bus.wdata[`EPI_BIT_GRP0] && !grp0_event |=> !flag_r.grp0)
      else $error("flag not cleared by write one");
   a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
      $past(bus.rd) && $past(bus.addr) == `EPI_ADDR_FLAGS |-> (bus_rdata & 8'h8F) == 8'h00)
      else $error("reserved bits not zero");
   a_level_request: assert property (@(posedge clk) disable iff (sys_rst)
      cpu_status_i && enable_r.ext && ext_level_low |-> irq_req.ext)
      else $error("held low level not requested");
   a_sync_delay: assert property (@(posedge clk) disable iff (sys_rst)
      ext_sync_r == $past(ext_irq_pin, 2))
      else $error("pin sampling delay wrong");

   c_rise: cover property (@(posedge clk) sense_r == epi_pkg::EPI_SENSE_RISE && ext_event);
   c_grp1: cover property (@(posedge clk) irq_req.grp1);
   c_level: cover property (@(posedge clk) ext_level_low && irq_req.ext);
   // ------------------------------
   // flag set and clear
   // ------------------------------
   a_ext_event_sets: assert property (@(posedge clk) disable iff (sys_rst)
      ext_event |=> flag_r.ext)
      else $error("external event lost");
   a_fall_sets: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(ext_sync_r) && sense_r == epi_pkg::EPI_SENSE_FALL |=> flag_r.ext)
      else $error("falling edge missed");
   a_change_sets: assert property (@(posedge clk) disable iff (sys_rst)
      $changed(ext_sync_r) && sense_r == epi_pkg::EPI_SENSE_CHANGE |=> flag_r.ext)
      else $error("pin change missed");
   a_rise_ignores_fall: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(ext_sync_r) && sense_r == epi_pkg::EPI_SENSE_RISE && !flag_r.ext && !bus.wr |=> !flag_r.ext)
      else $error("falling edge flagged in rise mode");
   a_level_no_event: assert property (@(posedge clk) disable iff (sys_rst)
      sense_r == epi_pkg::EPI_SENSE_LOW |-> !ext_event)
      else $error("edge event in level mode");
   a_grp1_sets: assert property (@(posedge clk) disable iff (sys_rst)
      grp1_event |=> flag_r.grp1)
      else $error("high group change lost");
   a_grp0_masked: assert property (@(posedge clk) disable iff (sys_rst)
      !flag_r.grp0 && mask_low_r == 8'h00 && !bus.wr |=> !flag_r.grp0)
      else $error("masked low group flagged");
   a_grp1_disabled: assert property (@(posedge clk) disable iff (sys_rst)
      !enable_r.grp1 |-> !grp1_event)
      else $error("high group event while disabled");
   a_grp0_disabled: assert property (@(posedge clk) disable iff (sys_rst)
      !enable_r.grp0 |-> !grp0_event)
      else $error("low group event while disabled");
   a_ext_ack_clears: assert property (@(posedge clk) disable iff (sys_rst)
      ack_ext && !ext_event |=> !flag_r.ext)
      else $error("external flag kept after vector");
   a_grp1_ack_clears: assert property (@(posedge clk) disable iff (sys_rst)
      ack_grp1 && !grp1_event |=> !flag_r.grp1)
      else $error("high group flag kept after vector");
   a_grp0_ack_clears: assert property (@(posedge clk) disable iff (sys_rst)
      ack_grp0 && !grp0_event |=> !flag_r.grp0)
      else $error("low group flag kept after vector");
   a_ext_write_clears: assert property (@(posedge clk) disable iff (sys_rst)
      flag_wr && bus.wdata[`EPI_BIT_EXT] && !ext_event |=> !flag_r.ext)
      else $error("external flag not cleared by write one");
   a_grp1_write_clears: assert property (@(posedge clk) disable iff (sys_rst)
      flag_wr && bus.wdata[`EPI_BIT_GRP1] && !grp1_event |=> !flag_r.grp1)
      else $error("high group flag not cleared by write one");
   a_ext_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
      ext_event && ack_ext |=> flag_r.ext)
      else $error("external set lost to clear");
   a_grp0_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
      grp0_event && ack_grp0 |=> flag_r.grp0)
      else $error("low group set lost to clear");
   a_grp1_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
      grp1_event && ack_grp1 |=> flag_r.grp1)
      else $error("high group set lost to clear");

   // ------------------------------
   // requests and wake
   // ------------------------------
   a_ext_vector: assert property (@(posedge clk) disable iff (sys_rst)
      cpu_status_i && enable_r.ext && flag_r.ext |-> irq_req.ext)
      else $error("external flag not vectored");
   a_grp1_gate: assert property (@(posedge clk) disable iff (sys_rst)
      irq_req.grp1 |-> cpu_status_i && enable_r.grp1 && flag_r.grp1)
      else $error("high group request without enables");
   a_grp0_gate: assert property (@(posedge clk) disable iff (sys_rst)
      irq_req.grp0 |-> cpu_status_i && enable_r.grp0 && flag_r.grp0)
      else $error("low group request without enables");
   a_grp1_vector: assert property (@(posedge clk) disable iff (sys_rst)
      cpu_status_i && enable_r.grp1 && flag_r.grp1 |-> irq_req.grp1)
      else $error("high group flag not vectored");
   a_grp0_vector: assert property (@(posedge clk) disable iff (sys_rst)
      cpu_status_i && enable_r.grp0 && flag_r.grp0 |-> irq_req.grp0)
      else $error("low group flag not vectored");
   a_level_high_quiet: assert property (@(posedge clk) disable iff (sys_rst)
      $past(sense_r) == epi_pkg::EPI_SENSE_LOW && sense_r == epi_pkg::EPI_SENSE_LOW && ext_sync_r |-> !irq_req.ext)
      else $error("level request with pin high");
   a_wake_level: assert property (@(posedge clk) disable iff (sys_rst)
      enable_r.ext && sense_r == epi_pkg::EPI_SENSE_LOW && !ext_irq_pin |-> wake_req)
      else $error("low level did not wake");
   a_wake_quiet: assert property (@(posedge clk) disable iff (sys_rst)
      !enable_r.ext && chg_armed == 12'h000 |-> !wake_req)
      else $error("wake without any enable");

   // ------------------------------
   // read port and sampling
   // ------------------------------
   a_enable_read: assert property (@(posedge clk) disable iff (sys_rst)
      $past(bus.rd) && $past(bus.addr) == `EPI_ADDR_ENABLE |-> (bus_rdata & 8'h8F) == 8'h00)
      else $error("reserved enable bits not zero");
   a_mask_high_read: assert property (@(posedge clk) disable iff (sys_rst)
      $past(bus.rd) && $past(bus.addr) == `EPI_ADDR_MASK_HIGH |-> bus_rdata[7:4] == 4'h0)
      else $error("reserved mask bits not zero");
   a_control_read: assert property (@(posedge clk) disable iff (sys_rst)
      $past(bus.rd) && $past(bus.addr) == `EPI_ADDR_CONTROL |-> bus_rdata[7:2] == 6'h00)
      else $error("control upper bits not zero");
   a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(bus.rd) |-> bus_rdata == 8'h00)
      else $error("read data outside its cycle");
   a_sync_chg: assert property (@(posedge clk) disable iff (sys_rst)
      chg_sync_r == $past(chg_inputs, 2))
      else $error("change input sampling delay wrong");
   a_sync_prev: assert property (@(posedge clk) disable iff (sys_rst)
      ext_prev_r == $past(ext_sync_r))
      else $error("previous sample out of step");

   c_set_clear: cover property (@(posedge clk) grp0_event && flag_wr && bus.wdata[`EPI_BIT_GRP0]);
   c_grp0: cover property (@(posedge clk) irq_req.grp0);
endmodule // epi_unit
`default_nettype wire

//--- external_pin_interrupt_unit_tb.sv
`include "epi_defines.svh"
`default_nettype none
module external_pin_interrupt_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, sys_rst, bus_wr, bus_rd, cpu_status_i, ack_ext, ack_grp1, ack_grp0;
   logic pin_lvl, ext_irq_pin, wake_req;
   logic [7:0] bus_addr, bus_wdata, bus_rdata;
   logic [11:0] chg_lvl, chg_inputs;
   epi_pkg::epi_irq_type irq_req;
   int err_count, compares;
   epi_src src (.clk(clk), .pin_lvl(pin_lvl), .chg_lvl(chg_lvl), .ext_irq_pin(ext_irq_pin),
      .chg_inputs(chg_inputs));
   epi_unit #(.CHG_WIDTH(12)) dut (.clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .ext_irq_pin(ext_irq_pin), .chg_inputs(chg_inputs), .cpu_status_i(cpu_status_i),
      .ack_ext(ack_ext), .ack_grp1(ack_grp1), .ack_grp0(ack_grp0), .irq_req(irq_req),
      .wake_req(wake_req));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ----------
   // helpers
   // ----------
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1;
      chk(what, exp, bus_rdata);
   endtask
   // six cycles covers source register, two sync stages and the flag
   task automatic step(input logic p, input logic [11:0] c);
      @(posedge clk);
      pin_lvl <= p;
      chg_lvl <= c;
      repeat (6) @(posedge clk);
      #1;
   endtask
   task automatic pulse(input logic [2:0] v);
      @(posedge clk);
      {ack_ext, ack_grp1, ack_grp0} <= v;
      @(posedge clk);
      {ack_ext, ack_grp1, ack_grp0} <= 3'h0;
   endtask
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ----------
   // sequence
   // ----------
   initial begin
      logic [7:0] regs [5];
      regs = '{`EPI_ADDR_MASK_LOW, `EPI_ADDR_MASK_HIGH, `EPI_ADDR_CONTROL, `EPI_ADDR_ENABLE, `EPI_ADDR_FLAGS};
      sys_rst = 1'b1;
      bus_addr = 8'h00;
      bus_wdata = 8'h00;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      cpu_status_i = 1'b0;
      {ack_ext, ack_grp1, ack_grp0} = 3'h0;
      pin_lvl = 1'b1;
      chg_lvl = 12'h000;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (regs[i]) rd(regs[i], 8'h00, "reset value");
      wr(`EPI_ADDR_ENABLE, 8'hFF);
      rd(`EPI_ADDR_ENABLE, 8'h70, "enable");
      wr(`EPI_ADDR_MASK_HIGH, 8'hFF);
      rd(`EPI_ADDR_MASK_HIGH, 8'h0F, "mask high");
      wr(`EPI_ADDR_MASK_LOW, 8'hFF);
      rd(`EPI_ADDR_MASK_LOW, 8'hFF, "mask low");
      rd(8'h20, 8'h00, "unmapped");
      $display("test registers done");
      @(posedge clk);
      cpu_status_i <= 1'b1;
      for (int m = 1; m < 4; m++) begin
         wr(`EPI_ADDR_CONTROL, 8'(m));
         step(1'b0, 12'h000);
         chk("ext request", (m != 3) ? 8'h01 : 8'h00, {7'h00, irq_req.ext});
         rd(`EPI_ADDR_FLAGS, (m != 3) ? 8'h40 : 8'h00, "flag fall");
         pulse(3'b100);
         rd(`EPI_ADDR_FLAGS, 8'h00, "flag ack");
         step(1'b1, 12'h000);
         rd(`EPI_ADDR_FLAGS, (m != 2) ? 8'h40 : 8'h00, "flag rise");
         wr(`EPI_ADDR_FLAGS, 8'h40);
         rd(`EPI_ADDR_FLAGS, 8'h00, "flag write one");
      end
      $display("test edge modes done");
      wr(`EPI_ADDR_CONTROL, 8'h00);
      step(1'b0, 12'h000);
      chk("level request", 8'h01, {7'h00, irq_req.ext});
      chk("wake", 8'h01, {7'h00, wake_req});
      rd(`EPI_ADDR_FLAGS, 8'h00, "level flag");
      @(posedge clk);
      cpu_status_i <= 1'b0;
      step(1'b0, 12'h000);
      chk("gated request", 8'h00, {7'h00, irq_req.ext});
      @(posedge clk);
      cpu_status_i <= 1'b1;
      step(1'b1, 12'h000);
      $display("test level mode done");
      wr(`EPI_ADDR_MASK_LOW, 8'h01);
      wr(`EPI_ADDR_MASK_HIGH, 8'h01);
      step(1'b1, 12'h202);
      rd(`EPI_ADDR_FLAGS, 8'h00, "masked change");
      step(1'b1, 12'h203);
      chk("grp0 request", 8'h01, {7'h00, irq_req.grp0});
      rd(`EPI_ADDR_FLAGS, 8'h10, "grp0 flag");
      pulse(3'b001);
      rd(`EPI_ADDR_FLAGS, 8'h00, "grp0 ack");
      step(1'b1, 12'h303);
      chk("grp1 request", 8'h01, {7'h00, irq_req.grp1});
      rd(`EPI_ADDR_FLAGS, 8'h20, "grp1 flag");
      pulse(3'b010);
      rd(`EPI_ADDR_FLAGS, 8'h00, "grp1 ack");
      chk("wake settled", 8'h00, {7'h00, wake_req});
      @(posedge clk);
      chg_lvl <= 12'h302;
      @(posedge clk);
      #1;
      chk("wake change", 8'h01, {7'h00, wake_req});
      $display("test pin change done");
      print_verdict();
   end
endmodule // external_pin_interrupt_unit_tb
`default_nettype wire
